/* hw/tdrb_pkg.sv */
// Package with constants and types of the technology diagnostic record builder
package tdrb_pkg;
	localparam logic [3:0] TDRB_ADR_CTRL   = 4'h0;
	localparam logic [3:0] TDRB_ADR_STATUS = 4'h1;
	localparam logic [3:0] TDRB_ADR_IRQ    = 4'h2;
	localparam logic [3:0] TDRB_ADR_MASK   = 4'h3;
	localparam logic [3:0] TDRB_ADR_REC0   = 4'h4;
	localparam logic [3:0] TDRB_ADR_REC1   = 4'h5;
	localparam logic [3:0] TDRB_ADR_REC2   = 4'h6;
	localparam logic [3:0] TDRB_ADR_REC3   = 4'h7;
	localparam logic [31:0] TDRB_CTRL_RST  = 32'h0000_0000;
	localparam int TDRB_CTRL_MODE_LSB      = 0;
	localparam int TDRB_CTRL_EN_BIT        = 2;
	localparam int TDRB_CTRL_ANALOG_BIT    = 3;
	localparam int TDRB_IRQ_IN_BIT         = 0;
	localparam int TDRB_IRQ_OUT_BIT        = 1;
	localparam logic [3:0] TDRB_CLASS_ANALOG  = 4'h5;
	localparam logic [3:0] TDRB_CLASS_DIGITAL = 4'hF;
	localparam logic [6:0] TDRB_CHTYPE_DI     = 7'h70;
	localparam logic [7:0] TDRB_DIAG_BITS     = 8'h08;
	localparam logic [7:0] TDRB_NUM_CHAN      = 8'h08;
	localparam int TDRB_LOST_BIT              = 6;
	localparam int TDRB_N_IN                  = 16;
	localparam int TDRB_N_TECH                = 3;
	typedef enum logic [1:0]
	{
		TDRB_MODE_COUNT = 2'b00,
		TDRB_MODE_FREQ  = 2'b01,
		TDRB_MODE_PWM   = 2'b10
	} tdrb_mode_type;
	typedef enum logic [1:0]
	{
		TDRB_ST_IDLE = 2'b00,
		TDRB_ST_DIAG = 2'b01
	} tdrb_state_type;
endpackage

/* hw/tdrb_ev_if.sv */
// Interface carrying one event channel between the top and its trackers
`timescale 1ns/10ps
interface tdrb_ev_if;
	logic ev;
	logic done;
	logic busy;
	logic lost;
	logic clr;
	modport trk (input ev, input done, input clr, output busy, output lost);
	modport top (output ev, output done, output clr, input busy, input lost);
endinterface

/* hw/tdrb_track.sv */
// Per event tracker: service state and sticky lost flag
`timescale 1ns/10ps
module tdrb_track
(
	input  wire logic   clock_i,
	input  wire logic   rst_b_i,
	tdrb_ev_if.trk      ch
);
	logic busy_q;
	logic lost_q;

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			busy_q <= 1'b0;
		else if (ch.ev)
			busy_q <= 1'b1;
		else if (ch.done)
			busy_q <= 1'b0;
	end

	// Set wins over clear so a loss in the clear cycle is kept
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			lost_q <= 1'b0;
		else if (ch.ev && busy_q)
			lost_q <= 1'b1;
		else if (ch.clr)
			lost_q <= 1'b0;
	end

	assign ch.busy = busy_q;
	assign ch.lost = lost_q;
endmodule

/* hw/tdrb_top.sv */
// Diagnostic record builder with Wishbone register access
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
module tdrb_top
	import tdrb_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        rst_b_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [5:2]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [15:0] in_ev_i,
	input  wire logic [11:0] tech_ev_i,
	input  wire logic        svc_done_i,
	input  wire logic        mod_fail_i,
	input  wire logic        ext_err_i,
	input  wire logic [6:0]  grp_err_i,
	output logic             irq_o
);
	import tdrb_pkg::*;

	// Tech events: index 4*k+j, counter k; j 0 gate closed, 1 gate opened, 2 limit, 3 compare.
	// In frequency mode only j=0 of each channel (end of integration) is used.
	localparam int NEV = TDRB_N_IN + 4 * TDRB_N_TECH;

	logic [NEV-1:0] ev_s1_q;
	logic [NEV-1:0] ev_s2_q;
	logic [NEV-1:0] ev_prev_q;
	logic [NEV-1:0] ev_rise;
	logic [NEV-1:0] ev_use;
	logic [NEV-1:0] busy;
	logic [NEV-1:0] lost;
	logic [NEV-1:0] clr_lost;
	logic [8:0]     st_s1_q;
	logic [8:0]     st_s2_q;
	logic           done_s1_q;
	logic           done_s2_q;
	logic           done_prev_q;
	logic           done_pulse;

	// Pins enter through two flip-flops before any logic
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			ev_s1_q   <= '0;
			ev_s2_q   <= '0;
			ev_prev_q <= '0;
			st_s1_q   <= '0;
			st_s2_q   <= '0;
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
			done_prev_q <= 1'b0;
		end
		else
		begin
			ev_s1_q   <= {tech_ev_i, in_ev_i};
			ev_s2_q   <= ev_s1_q;
			ev_prev_q <= ev_s2_q;
			st_s1_q   <= {grp_err_i, ext_err_i, mod_fail_i};
			st_s2_q   <= st_s1_q;
			done_s1_q <= svc_done_i;
			done_s2_q <= done_s1_q;
			done_prev_q <= done_s2_q;
		end
	end

	assign ev_rise    = ev_s2_q & ~ev_prev_q;
	assign done_pulse = done_s2_q & ~done_prev_q;

	logic [31:0]   ctrl_q;
	tdrb_mode_type mode;
	logic          diag_en;

	always_comb
	begin
		case (ctrl_q[TDRB_CTRL_MODE_LSB +: 2])
			2'b01:   mode = TDRB_MODE_FREQ;
			2'b10:   mode = TDRB_MODE_PWM;
			default: mode = TDRB_MODE_COUNT;
		endcase
	end
	assign diag_en = ctrl_q[TDRB_CTRL_EN_BIT];

	// Events with no process interrupt in the current mode are masked
	always_comb
	begin
		ev_use = ev_rise;
		for (int k = 0; k < TDRB_N_TECH; k++)
		begin
			if (mode == TDRB_MODE_PWM)
				ev_use[TDRB_N_IN + 4*k +: 4] = 4'h0;
			else if (mode == TDRB_MODE_FREQ)
				ev_use[TDRB_N_IN + 4*k + 1 +: 3] = 3'h0;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NEV; g++)
		begin : g_trk
			tdrb_ev_if ch ();
			assign ch.ev   = ev_use[g];
			assign ch.done = done_pulse;
			assign ch.clr  = clr_lost[g];
			assign busy[g] = ch.busy;
			assign lost[g] = ch.lost;
			tdrb_track u_trk
			(
				.clock_i (clock_i),
				.rst_b_i (rst_b_i),
				.ch      (ch)
			);
		end
	endgenerate

	// Error state
	logic          any_err;
	logic          err_prev_q;
	logic          err_fell;
	tdrb_state_type st_q;
	logic [7:0]    rec_q [0:15];
	logic [7:0]    rec_d [0:15];
	logic          cap_in;
	logic          cap_out;

	assign any_err  = (|lost) | st_s2_q[0] | st_s2_q[1] | (|st_s2_q[8:2]);
	assign err_fell = err_prev_q & ~any_err;
	assign cap_in   = diag_en && any_err && (st_q == TDRB_ST_IDLE);
	assign cap_out  = diag_en && err_fell && (st_q == TDRB_ST_DIAG);

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			err_prev_q <= 1'b0;
		else
			err_prev_q <= any_err;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			st_q <= TDRB_ST_IDLE;
		else
		begin
			case (st_q)
				TDRB_ST_IDLE: if (cap_in) st_q <= TDRB_ST_DIAG;
				TDRB_ST_DIAG: if (!any_err || !diag_en) st_q <= TDRB_ST_IDLE;
				default:      st_q <= TDRB_ST_IDLE;
			endcase
		end
	end

	// Record image, built fresh each cycle and frozen only on an event
	always_comb
	begin
		for (int i = 0; i < 16; i++)
			rec_d[i] = 8'h00;
		rec_d[0][0] = st_s2_q[0];
		rec_d[0][2] = st_s2_q[1];
		rec_d[0][3] = (|st_s2_q[8:2]) | (|lost);
		rec_d[1][3:0] = ctrl_q[TDRB_CTRL_ANALOG_BIT] ? TDRB_CLASS_ANALOG
			: TDRB_CLASS_DIGITAL;
		rec_d[1][4] = 1'b1;
		rec_d[3][TDRB_LOST_BIT] = |lost;
		rec_d[4] = {1'b0, TDRB_CHTYPE_DI};
		rec_d[5] = TDRB_DIAG_BITS;
		rec_d[6] = TDRB_NUM_CHAN;
		rec_d[7][3:0] = st_s2_q[5:2];
		if (mode != TDRB_MODE_PWM)
			rec_d[7][6:4] = st_s2_q[8:6];
		for (int i = 0; i < TDRB_N_IN; i++)
			rec_d[8 + i/4][2*(i%4)] = lost[i];
		for (int k = 0; k < TDRB_N_TECH; k++)
		begin
			if (mode == TDRB_MODE_COUNT)
			begin
				rec_d[12+k][0] = lost[TDRB_N_IN + 4*k];
				rec_d[12+k][2] = lost[TDRB_N_IN + 4*k + 1];
				rec_d[12+k][4] = lost[TDRB_N_IN + 4*k + 2];
				rec_d[12+k][6] = lost[TDRB_N_IN + 4*k + 3];
			end
			else if (mode == TDRB_MODE_FREQ)
				rec_d[12+k][0] = lost[TDRB_N_IN + 4*k];
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			for (int i = 0; i < 16; i++)
				rec_q[i] <= 8'h00;
		end
		else if (cap_in)
		begin
			for (int i = 0; i < 16; i++)
				rec_q[i] <= rec_d[i];
		end
		else if (cap_out)
		begin
			rec_q[0] <= rec_d[0];
			rec_q[1] <= rec_d[1];
			rec_q[2] <= 8'h00;
			rec_q[3] <= 8'h00;
			for (int i = 4; i < 16; i++)
				rec_q[i] <= rec_d[i];
		end
	end

	// Wishbone slave
	logic        req;
	logic        ack_q;
	logic [31:0] rdat;
	logic [1:0]  irq_st_q;
	logic [1:0]  irq_mask_q;
	logic        rd_irq;

	assign req    = wb_cyc_i & wb_stb_i & ~ack_q;
	assign rd_irq = req & ~wb_we_i & (wb_adr_i == TDRB_ADR_IRQ);

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			ack_q <= 1'b0;
		else
			ack_q <= req;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			ctrl_q <= TDRB_CTRL_RST;
		else if (req && wb_we_i && wb_adr_i == TDRB_ADR_CTRL && wb_sel_i[0])
			ctrl_q <= {28'h0, wb_dat_i[3:0]};
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			irq_mask_q <= 2'h0;
		else if (req && wb_we_i && wb_adr_i == TDRB_ADR_MASK && wb_sel_i[0])
			irq_mask_q <= wb_dat_i[1:0];
	end

	// Read of the IRQ register clears; a new event in the same cycle wins
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			irq_st_q <= 2'h0;
		else
		begin
			irq_st_q[TDRB_IRQ_IN_BIT]  <= cap_in | (irq_st_q[TDRB_IRQ_IN_BIT] & ~rd_irq);
			irq_st_q[TDRB_IRQ_OUT_BIT] <= cap_out | (irq_st_q[TDRB_IRQ_OUT_BIT] & ~rd_irq);
		end
	end

	// Service of the pending interrupt clears the lost flags, so the error can fall.
	// Clearing on the outgoing capture instead would deadlock, since that needs no error.
	assign clr_lost = {NEV{done_pulse}};

	always_comb
	begin
		case (wb_adr_i)
			TDRB_ADR_CTRL:   rdat = ctrl_q;
			TDRB_ADR_STATUS: rdat = {30'h0, any_err, (st_q == TDRB_ST_DIAG)};
			TDRB_ADR_IRQ:    rdat = {30'h0, irq_st_q};
			TDRB_ADR_MASK:   rdat = {30'h0, irq_mask_q};
			TDRB_ADR_REC0:   rdat = {rec_q[3], rec_q[2], rec_q[1], rec_q[0]};
			TDRB_ADR_REC1:   rdat = {rec_q[7], rec_q[6], rec_q[5], rec_q[4]};
			TDRB_ADR_REC2:   rdat = {rec_q[11], rec_q[10], rec_q[9], rec_q[8]};
			TDRB_ADR_REC3:   rdat = {rec_q[15], rec_q[14], rec_q[13], rec_q[12]};
			default:         rdat = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			wb_dat_o <= 32'h0000_0000;
		else if (req && !wb_we_i)
			wb_dat_o <= rdat;
	end

	assign wb_ack_o = ack_q;
	assign irq_o    = |(irq_st_q & irq_mask_q);

	// Checks
	a_out_zero_tail: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		cap_out |=> (rec_q[2] == 8'h00 && rec_q[3] == 8'h00))
		else $error("outgoing record bytes 2 and 3 not zero");
	a_byte0_fixed: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(rec_q[0][1] == 1'b0 && rec_q[0][7:4] == 4'h0))
		else $error("fixed bits of byte 0 set");
	a_byte1_class: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		cap_in |=> (rec_q[1][7:5] == 3'h0 && rec_q[1][4]
		&& (rec_q[1][3:0] == TDRB_CLASS_ANALOG || rec_q[1][3:0] == TDRB_CLASS_DIGITAL)))
		else $error("byte 1 class field wrong");
	a_ext_header: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		cap_in |=> (rec_q[4] == 8'h70 && rec_q[5] == 8'h08 && rec_q[6] == 8'h08))
		else $error("extended header bytes wrong");
	a_pwm_reserved: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(cap_in && mode == TDRB_MODE_PWM) |=> (rec_q[7][7:4] == 4'h0
		&& rec_q[12] == 8'h00 && rec_q[13] == 8'h00 && rec_q[15] == 8'h00))
		else $error("reserved pwm bytes not zero");
	a_odd_bits_zero: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		((rec_q[8] & 8'hAA) == 8'h00 && (rec_q[11] & 8'hAA) == 8'h00))
		else $error("odd lost bits set");
	a_lost_raises: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(|(ev_use & busy)) |=> ((lost & $past(ev_use & busy)) == $past(ev_use & busy)))
		else $error("lost flag not raised");
	a_snapshot_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(!cap_in && !cap_out) |=> $stable(rec_q[0]) && $stable(rec_q[8]))
		else $error("record changed without event");
	a_irq_lost_bit: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		cap_in |=> (rec_q[3][TDRB_LOST_BIT] == (|$past(lost)) && rec_q[15] == 8'h00))
		else $error("lost bit of byte 3 wrong");
endmodule

/* bench/tdrb_testbench.sv */
// Self-checking bench of the diagnostic record builder
`timescale 1ns/10ps
module testbench;
	import tdrb_pkg::*;
	logic        clock_i = 1'h0;
	logic        rst_b_i = 1'h0;
	logic        cyc = 1'h0;
	logic        stb = 1'h0;
	logic        we = 1'h0;
	logic [5:2]  adr = 4'h0;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic [15:0] in_ev = 16'h0;
	logic [11:0] tech_ev = 12'h0;
	logic        svc = 1'h0;
	logic        mf = 1'h0;
	logic        ee = 1'h0;
	logic [6:0]  grp = 7'h0;
	logic        irq;
	logic [63:0] exp_q[$];
	logic [63:0] note;
	logic        an;
	logic        f;
	logic        x;
	logic [6:0]  g;
	logic [7:0]  b1;
	int          i;
	int          k;
	int          j;
	int          n_mismatch = 0;
	int          checked = 0;

	always #2 clock_i = ~clock_i;

	tdrb_top tdrb_top_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .in_ev_i(in_ev), .tech_ev_i(tech_ev),
		.svc_done_i(svc), .mod_fail_i(mf), .ext_err_i(ee), .grp_err_i(grp), .irq_o(irq));

	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_irq(input logic exp);
		checked++;
		if (irq !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t irq got=%h exp=%h", $time, irq, exp);
		end
	endtask

	// Read data is judged at the ack edge, before the master releases the cycle
	always @(posedge clock_i)
		if (ack === 1'h1 && we === 1'h0)
		begin
			note = exp_q.pop_front();
			cmp32(rdat & note[63:32], note[31:0]);
		end

	// Classic cycle; no latency assumed, only the bounded wait for ack
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF);
		int n;
		n = 0;
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		@(posedge clock_i);
		while (ack !== 1'h1 && n < 50)
		begin
			n++;
			@(posedge clock_i);
		end
		if (n == 50)
		begin
			n_mismatch++;
			test_done();
		end
		cyc <= 1'h0;
		stb <= 1'h0;
		sel <= 4'h0;
		@(posedge clock_i);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFF_FFFF);
		exp_q.push_back({m, e & m});
		bus(1'h0, a, 32'h0);
	endtask

	task automatic do_reset();
		rst_b_i <= 1'h0;
		tick(16);
		rst_b_i <= 1'h1;
		tick(1);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		tick(5000);
		n_mismatch++;
		test_done();
	end

	initial
	begin
		void'($urandom(23));
		@(posedge clock_i);
		do_reset();
		rd(TDRB_ADR_CTRL, 32'h0);
		rd(TDRB_ADR_IRQ, 32'h0);
		bus(1'h1, TDRB_ADR_MASK, 32'h3);
		rd(TDRB_ADR_MASK, 32'h3);
		bus(1'h1, TDRB_ADR_MASK, 32'h0, 4'hE);
		rd(TDRB_ADR_MASK, 32'h3);
		bus(1'h1, TDRB_ADR_REC0, 32'hFFFF_FFFF);
		rd(TDRB_ADR_REC0, 32'h0);
		bus(1'h1, 4'h9, 32'h5);
		rd(4'h9, 32'h0);
		$display("test regs done");
		// Error levels in every mode; only the outgoing edge is unmasked
		for (int md = 0; md < 3; md++)
		begin
			an = 1'($urandom);
			g = 7'($urandom) | 7'h01;
			f = 1'($urandom);
			x = 1'($urandom);
			bus(1'h1, TDRB_ADR_CTRL, {28'h0, an, 1'h1, 2'(md)});
			bus(1'h1, TDRB_ADR_MASK, 32'h2);
			mf <= f;
			ee <= x;
			grp <= g;
			tick(10);
			cmp_irq(1'h0);
			rd(TDRB_ADR_STATUS, 32'h3);
			b1 = {4'h1, an ? TDRB_CLASS_ANALOG : TDRB_CLASS_DIGITAL};
			rd(TDRB_ADR_REC0, {16'h0, b1, 4'h0, 1'h1, x, 1'h0, f});
			rd(TDRB_ADR_REC1, {md == 2 ? {4'h0, g[3:0]} : {1'h0, g}, TDRB_NUM_CHAN,
				TDRB_DIAG_BITS, 1'h0, TDRB_CHTYPE_DI});
			rd(TDRB_ADR_REC2, 32'h0);
			rd(TDRB_ADR_REC3, 32'h0);
			mf <= 1'h0;
			ee <= 1'h0;
			grp <= 7'h0;
			tick(10);
			cmp_irq(1'h1);
			rd(TDRB_ADR_STATUS, 32'h0);
			rd(TDRB_ADR_REC0, 32'h0, 32'hFFFF_0000);
			rd(TDRB_ADR_IRQ, 32'h3);
			cmp_irq(1'h0);
		end
		$display("test base done");
		// Third event before service is lost; the first service clears busy before the second event
		for (int md = 0; md < 2; md++)
		begin
			do_reset();
			i = $urandom % 16;
			k = $urandom % 3;
			j = md ? 0 : $urandom % 4;
			bus(1'h1, TDRB_ADR_CTRL, 32'(4 + md));
			bus(1'h1, TDRB_ADR_MASK, 32'h1);
			for (int p = 0; p < 3; p++)
			begin
				in_ev[i] <= 1'h1;
				tech_ev[4 * k + j] <= 1'h1;
				tick(2);
				in_ev <= 16'h0;
				tech_ev <= 12'h0;
				svc <= (p == 0);
				tick(4);
				svc <= 1'h0;
				tick(2);
			end
			tick(10);
			cmp_irq(1'h1);
			rd(TDRB_ADR_REC0, 32'h4000_1F08);
			rd(TDRB_ADR_REC1, {8'h0, TDRB_NUM_CHAN, TDRB_DIAG_BITS, 1'h0, TDRB_CHTYPE_DI});
			rd(TDRB_ADR_REC2, 32'h1 << (8 * (i / 4) + 2 * (i % 4)));
			rd(TDRB_ADR_REC3, 32'h1 << (8 * k + 2 * j));
			rd(TDRB_ADR_IRQ, 32'h1);
			cmp_irq(1'h0);
			// Servicing the pending interrupt removes the error and issues the outgoing record
			svc <= 1'h1;
			bus(1'h1, TDRB_ADR_MASK, 32'h2);
			svc <= 1'h0;
			tick(8);
			cmp_irq(1'h1);
			rd(TDRB_ADR_REC0, 32'h0, 32'hFFFF_0000);
			rd(TDRB_ADR_REC2, 32'h0);
			rd(TDRB_ADR_IRQ, 32'h2);
			cmp_irq(1'h0);
		end
		$display("test lost done");
		test_done();
	end
endmodule
